// File: hw/mpctd_cfg.svh
`ifndef MPCTD_CFG_SVH
`define MPCTD_CFG_SVH

`define MPCTD_CLK_PERIOD_NS          8
`define MPCTD_STROBE_DRIVE_DELAY_NS  20
`define MPCTD_SDO_CYC                (`MPCTD_STROBE_DRIVE_DELAY_NS / `MPCTD_CLK_PERIOD_NS)
`define MPCTD_ZQCAL_NS               1000
`define MPCTD_ZQCAL_CYC              ((`MPCTD_ZQCAL_NS + `MPCTD_CLK_PERIOD_NS - 1) / `MPCTD_CLK_PERIOD_NS)
`define MPCTD_BURST_BEATS            16
`define MPCTD_FIFO_ENTRIES           5

`define MPCTD_OP_RD_FIFO             7'h41
`define MPCTD_OP_RD_CAL              7'h43
`define MPCTD_OP_WR_FIFO             7'h47
`define MPCTD_OP_OSC_STOP            7'h4D
`define MPCTD_OP_ZQ_BEGIN            7'h4F
`define MPCTD_OP_ZQ_CAPTURE          7'h51

`define MPCTD_CA_MPC                 5'h00
`define MPCTD_CA_CAS2                5'h12

`define MPCTD_OFF_TRAIN_CTRL         8'h00
`define MPCTD_OFF_PATTERN_LOW        8'h04
`define MPCTD_OFF_PATTERN_HIGH       8'h08
`define MPCTD_OFF_INVERT_MASK        8'h0C
`define MPCTD_OFF_LATENCY            8'h10
`define MPCTD_OFF_DMI_ENABLES        8'h14
`define MPCTD_OFF_OSC_COUNT_LOW      8'h18
`define MPCTD_OFF_OSC_COUNT_HIGH     8'h1C
`define MPCTD_OFF_OSC_AUTO           8'h20
`define MPCTD_OFF_STATUS             8'h24

`define MPCTD_BIT_OSC_START          0
`define MPCTD_BIT_TRAIN              1
`define MPCTD_RL_LSB                 0
`define MPCTD_WL_LSB                 8

`define MPCTD_RST_RL                 6'h06
`define MPCTD_RST_WL                 6'h04
`define MPCTD_RST_PATTERN_LOW        8'h55
`define MPCTD_RST_PATTERN_HIGH       8'h55

`endif

// File: hw/mpctd_pkg.sv
package mpctd_pkg;

  typedef enum logic [2:0] {
    OP_NOP        = 3'b000,
    OP_RD_FIFO    = 3'b001,
    OP_RD_CAL     = 3'b010,
    OP_WR_FIFO    = 3'b011,
    OP_OSC_STOP   = 3'b100,
    OP_ZQ_BEGIN   = 3'b101,
    OP_ZQ_CAPTURE = 3'b110,
    OP_RESERVED   = 3'b111
  } mpctd_op_e;

  typedef enum logic [2:0] {
    C_IDLE  = 3'b000,
    C_OPER  = 3'b001,
    C_EXEC  = 3'b010,
    C_CAS1  = 3'b011,
    C_CAS2B = 3'b100
  } mpctd_cmd_state_e;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_LAT  = 2'b01,
    B_DATA = 2'b10
  } mpctd_burst_state_e;

endpackage : mpctd_pkg

// File: hw/mpctd_if.sv
interface mpctd_cmd_if;
  logic [6:0]            op;
  mpctd_pkg::mpctd_op_e  kind;
  logic                  needs_cas;
  modport dec  (input op, output kind, output needs_cas);
  modport core (output op, input kind, input needs_cas);
endinterface : mpctd_cmd_if

interface mpctd_mem_if #(
  parameter int W  = 18,
  parameter int AW = 7
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport core (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface : mpctd_mem_if

// File: hw/mpctd_op_decode.sv
`include "mpctd_cfg.svh"
module mpctd_op_decode (
  mpctd_cmd_if.dec cmd
);

  function automatic mpctd_pkg::mpctd_op_e decode_op(input logic [6:0] op);
    if (!op[6])                              decode_op = mpctd_pkg::OP_NOP;
    else if (op == `MPCTD_OP_RD_FIFO)        decode_op = mpctd_pkg::OP_RD_FIFO;
    else if (op == `MPCTD_OP_RD_CAL)         decode_op = mpctd_pkg::OP_RD_CAL;
    else if (op == `MPCTD_OP_WR_FIFO)        decode_op = mpctd_pkg::OP_WR_FIFO;
    else if (op == `MPCTD_OP_OSC_STOP)       decode_op = mpctd_pkg::OP_OSC_STOP;
    else if (op == `MPCTD_OP_ZQ_BEGIN)       decode_op = mpctd_pkg::OP_ZQ_BEGIN;
    else if (op == `MPCTD_OP_ZQ_CAPTURE)     decode_op = mpctd_pkg::OP_ZQ_CAPTURE;
    else                                     decode_op = mpctd_pkg::OP_RESERVED;
  endfunction : decode_op

  assign cmd.kind      = decode_op(cmd.op);
  assign cmd.needs_cas = (cmd.kind == mpctd_pkg::OP_RD_FIFO) ||
                         (cmd.kind == mpctd_pkg::OP_RD_CAL)  ||
                         (cmd.kind == mpctd_pkg::OP_WR_FIFO);

endmodule : mpctd_op_decode

// File: hw/mpctd_fifo_mem.sv
module mpctd_fifo_mem #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 80
) (
  input wire logic clk,
  input wire logic ce,
  mpctd_mem_if.mem port
);

  logic [WIDTH-1:0] store [DEPTH];
  logic [WIDTH-1:0] rd_reg;

  // no reset: unwritten entries read back undefined by design
  always_ff @(posedge clk) begin
    if (ce) begin
      if (port.wr_en) begin
        store[port.wr_addr] <= port.wr_data;
      end
      rd_reg <= store[port.rd_addr];
    end
  end

  assign port.rd_data = rd_reg;

endmodule : mpctd_fifo_mem

// File: hw/mpctd_top.sv
// Function
// - training bit set: drive true strobe low, complement high until calibration read
// - training mode omits read preamble; strobes toggle as normal burst after latency
// - calibration read gives 16 beats: low pattern bits then high pattern bits
// - pins whose invert-mask bit is one get the calibration pattern inverted
// - pattern also on mask/inversion pins, never bus-inverted
// - clearing training bit leaves training mode within strobe-drive delay
// - strobe-drive delay is the larger of 12 clocks and 20 ns; the code counts the 20 ns only, as 2 clk
// - operand bit six taken at first command edge; zero means no operation
// - latency counts from second rising edge of the trailing CAS-2
// - nop, oscillator and impedance commands stand alone without CAS-2
// - decode 0xxxxxx nop, 1000001 fifo read, 1000011 cal read, 1000111 fifo write
// - 1001101 stops oscillator, 1001111 starts impedance calibration, 1010001 latches it
// - fifo write and read always use sixteen-beat bursts
// - fifo read uses ordinary read latency and strobe timing
// - fifo read pointer wraps after five reads; unwritten entries undefined
// - fifo training drives both mask pins when inversion or masking enabled
// - fifo write accepted with banks open, refresh, or self refresh
// - oscillator stop stores count into the two count result registers
// - impedance calibration start while running is ignored
//
// Implementation choices: the placing of the registers and the APB register port.
`include "mpctd_cfg.svh"
module mpctd_top #(
  parameter int FIFO_ENTRIES = `MPCTD_FIFO_ENTRIES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ck_t,
  input  wire logic        cs,
  input  wire logic [5:0]  ca,
  input  wire logic [15:0] dq_in,
  input  wire logic [1:0]  dmi_in,
  output logic      [15:0] dq_out,
  output logic             dq_oe,
  output logic      [1:0]  mask_inversion_pin_out,
  output logic             mask_inversion_pin_oe,
  output logic             dqs_t,
  output logic             dqs_c,
  output logic             dqs_oe,
  output logic             impedance_cal_capture
);

  localparam int BEATS = `MPCTD_BURST_BEATS;

  // pin synchronisers and edge finder
  logic [25:0] pin_meta_reg;
  logic [25:0] pin_sync_reg;
  logic [25:0] pin_hist_reg;
  wire  [25:0] pin_raw = {dmi_in, dq_in, ca, cs, ck_t};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_hist_reg <= '0;
    end else if (ce) begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_hist_reg <= pin_sync_reg;
    end
  end

  // command pins taken one clk before the edge is seen, away from their change
  wire        ck_rise = pin_sync_reg[0] & ~pin_hist_reg[0];
  wire        ck_fall = ~pin_sync_reg[0] & pin_hist_reg[0];
  wire        ck_edge = ck_rise | ck_fall;
  wire        cs_h    = pin_hist_reg[1];
  wire [5:0]  ca_h    = pin_hist_reg[7:2];
  wire [15:0] dq_h    = pin_hist_reg[23:8];
  wire [1:0]  dmi_h   = pin_hist_reg[25:24];

  // software-visible state
  logic        train_req_reg;
  logic        train_active_reg;
  logic [1:0]  sdo_cnt_reg;
  logic [7:0]  pattern_low_register;
  logic [7:0]  pattern_high_register;
  logic [15:0] invert_mask_reg;
  logic [5:0]  read_latency_reg;
  logic [5:0]  write_latency_reg;
  logic [2:0]  dmi_en_reg;
  logic [7:0]  osc_count_low_register;
  logic [7:0]  osc_count_high_register;
  logic [15:0] osc_auto_reg;
  logic        osc_run_reg;
  logic [15:0] osc_cnt_reg;
  logic [15:0] osc_clks_reg;
  logic [7:0]  zq_cnt_reg;
  logic [2:0]  wr_ptr_reg;
  logic [2:0]  rd_ptr_reg;

  // APB slave: one wait state, registered answer
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [31:0] rd_val;
  logic        rd_hit;

  wire apb_access = psel & penable;
  wire apb_fire   = apb_access & pready_reg;
  wire apb_wr     = apb_fire & pwrite & rd_hit;
  wire wr_ctrl    = apb_wr & (paddr == `MPCTD_OFF_TRAIN_CTRL);
  wire osc_start  = wr_ctrl & pwdata[`MPCTD_BIT_OSC_START];
  wire zq_busy    = (zq_cnt_reg != 8'h00);

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      `MPCTD_OFF_TRAIN_CTRL:     rd_val[`MPCTD_BIT_TRAIN] = train_req_reg;
      `MPCTD_OFF_PATTERN_LOW:    rd_val[7:0] = pattern_low_register;
      `MPCTD_OFF_PATTERN_HIGH:   rd_val[7:0] = pattern_high_register;
      `MPCTD_OFF_INVERT_MASK:    rd_val[15:0] = invert_mask_reg;
      `MPCTD_OFF_LATENCY:        rd_val = {18'h0, write_latency_reg, 2'h0, read_latency_reg};
      `MPCTD_OFF_DMI_ENABLES:    rd_val[2:0] = dmi_en_reg;
      `MPCTD_OFF_OSC_COUNT_LOW:  rd_val[7:0] = osc_count_low_register;
      `MPCTD_OFF_OSC_COUNT_HIGH: rd_val[7:0] = osc_count_high_register;
      `MPCTD_OFF_OSC_AUTO:       rd_val[15:0] = osc_auto_reg;
      `MPCTD_OFF_STATUS:         rd_val[8:0] = {wr_ptr_reg, rd_ptr_reg, osc_run_reg, zq_busy, train_active_reg};
      default:                   rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg  <= apb_access & ~pready_reg;
      prdata_reg  <= (apb_access & ~pready_reg & ~pwrite) ? rd_val : 32'h0;
      pslverr_reg <= apb_access & ~pready_reg & ~rd_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      train_req_reg         <= 1'b0;
      pattern_low_register  <= `MPCTD_RST_PATTERN_LOW;
      pattern_high_register <= `MPCTD_RST_PATTERN_HIGH;
      invert_mask_reg       <= 16'h0000;
      read_latency_reg      <= `MPCTD_RST_RL;
      write_latency_reg     <= `MPCTD_RST_WL;
      dmi_en_reg            <= 3'h0;
      osc_auto_reg          <= 16'h0000;
    end else if (ce && apb_wr) begin
      case (paddr)
        `MPCTD_OFF_TRAIN_CTRL:   train_req_reg <= pwdata[`MPCTD_BIT_TRAIN];
        `MPCTD_OFF_PATTERN_LOW:  pattern_low_register <= pwdata[7:0];
        `MPCTD_OFF_PATTERN_HIGH: pattern_high_register <= pwdata[7:0];
        `MPCTD_OFF_INVERT_MASK:  invert_mask_reg <= pwdata[15:0];
        `MPCTD_OFF_LATENCY: begin
          read_latency_reg  <= pwdata[`MPCTD_RL_LSB +: 6];
          write_latency_reg <= pwdata[`MPCTD_WL_LSB +: 6];
        end
        `MPCTD_OFF_DMI_ENABLES:  dmi_en_reg <= pwdata[2:0];
        `MPCTD_OFF_OSC_AUTO:     osc_auto_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // training mode follows its control bit after the strobe-drive delay
  wire sdo_done = (sdo_cnt_reg == 2'(`MPCTD_SDO_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      train_active_reg <= 1'b0;
      sdo_cnt_reg      <= 2'h0;
    end else if (ce) begin
      if (train_active_reg == train_req_reg) begin
        sdo_cnt_reg <= 2'h0;
      end else if (sdo_done) begin
        train_active_reg <= train_req_reg;
        sdo_cnt_reg      <= 2'h0;
      end else begin
        sdo_cnt_reg <= sdo_cnt_reg + 2'h1;
      end
    end
  end

  // operand decoding
  mpctd_cmd_if cmd_bus ();
  mpctd_op_decode u_decode (
    .cmd (cmd_bus.dec)
  );

  mpctd_pkg::mpctd_cmd_state_e cmd_state_reg;
  mpctd_pkg::mpctd_op_e        pend_kind_reg;
  logic [6:0]                  op_reg;

  assign cmd_bus.op = op_reg;

  wire exec_now  = (cmd_state_reg == mpctd_pkg::C_EXEC);
  wire stop_cmd  = exec_now & (cmd_bus.kind == mpctd_pkg::OP_OSC_STOP);
  wire zq_begin  = exec_now & (cmd_bus.kind == mpctd_pkg::OP_ZQ_BEGIN);
  wire zq_latch  = exec_now & (cmd_bus.kind == mpctd_pkg::OP_ZQ_CAPTURE);
  wire launch    = ck_rise & (cmd_state_reg == mpctd_pkg::C_CAS2B);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_state_reg <= mpctd_pkg::C_IDLE;
      op_reg        <= 7'h00;
      pend_kind_reg <= mpctd_pkg::OP_NOP;
    end else if (ce) begin
      unique case (cmd_state_reg)
        mpctd_pkg::C_IDLE: begin
          if (ck_rise && cs_h && ca_h[4:0] == `MPCTD_CA_MPC) begin
            op_reg[6]     <= ca_h[5];
            cmd_state_reg <= mpctd_pkg::C_OPER;
          end
        end
        mpctd_pkg::C_OPER: begin
          if (ck_rise) begin
            op_reg[5:0]   <= ca_h;
            cmd_state_reg <= mpctd_pkg::C_EXEC;
          end
        end
        mpctd_pkg::C_EXEC: begin
          pend_kind_reg <= cmd_bus.kind;
          // fifo write taken whatever the bank or refresh state
          cmd_state_reg <= cmd_bus.needs_cas ? mpctd_pkg::C_CAS1 : mpctd_pkg::C_IDLE;
        end
        mpctd_pkg::C_CAS1: begin
          // anything but CAS-2 here drops the training command
          if (ck_rise) begin
            cmd_state_reg <= (cs_h && ca_h[4:0] == `MPCTD_CA_CAS2) ? mpctd_pkg::C_CAS2B
                                                                    : mpctd_pkg::C_IDLE;
          end
        end
        mpctd_pkg::C_CAS2B: begin
          if (ck_rise) begin
            cmd_state_reg <= mpctd_pkg::C_IDLE;
          end
        end
        default: cmd_state_reg <= mpctd_pkg::C_IDLE;
      endcase
    end
  end

  // interval oscillator and impedance calibration
  wire auto_hit = osc_run_reg & (osc_auto_reg != 16'h0000) & (osc_clks_reg == osc_auto_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_run_reg             <= 1'b0;
      osc_cnt_reg             <= 16'h0000;
      osc_clks_reg            <= 16'h0000;
      osc_count_low_register  <= 8'h00;
      osc_count_high_register <= 8'h00;
    end else if (ce) begin
      if (osc_start && !osc_run_reg) begin
        osc_run_reg  <= 1'b1;
        osc_cnt_reg  <= 16'h0000;
        osc_clks_reg <= 16'h0000;
      end else if (osc_run_reg && (stop_cmd || auto_hit)) begin
        osc_run_reg             <= 1'b0;
        osc_count_low_register  <= osc_cnt_reg[7:0];
        osc_count_high_register <= osc_cnt_reg[15:8];
      end else if (osc_run_reg) begin
        // saturates so software can spot an overflowed run
        osc_cnt_reg  <= (osc_cnt_reg == 16'hFFFF) ? osc_cnt_reg : osc_cnt_reg + 16'h0001;
        osc_clks_reg <= osc_clks_reg + 16'h0001;
      end
    end
  end

  logic zq_capture_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zq_cnt_reg     <= 8'h00;
      zq_capture_reg <= 1'b0;
    end else if (ce) begin
      zq_capture_reg <= zq_latch;
      if (zq_begin && !zq_busy) begin
        zq_cnt_reg <= 8'(`MPCTD_ZQCAL_CYC);
      end else if (zq_busy) begin
        zq_cnt_reg <= zq_cnt_reg - 8'h01;
      end
    end
  end

  // burst engine
  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = (p == 3'(FIFO_ENTRIES - 1)) ? 3'h0 : p + 3'h1;
  endfunction : ptr_inc

  mpctd_pkg::mpctd_burst_state_e burst_state_reg;
  mpctd_pkg::mpctd_op_e          burst_kind_reg;
  logic [5:0]                    lat_cnt_reg;
  logic [4:0]                    beat_idx_reg;

  wire       lat_done    = (burst_state_reg == mpctd_pkg::B_LAT) & ck_rise & (lat_cnt_reg <= 6'h01);
  wire       data_edge   = (burst_state_reg == mpctd_pkg::B_DATA) & ck_edge;
  wire       burst_end   = data_edge & (beat_idx_reg == 5'(BEATS));
  wire       beat_strobe = lat_done | (data_edge & ~burst_end);
  wire [3:0] cur_beat    = beat_idx_reg[3:0];
  wire       is_cal      = (burst_kind_reg == mpctd_pkg::OP_RD_CAL);
  wire       is_rdf      = (burst_kind_reg == mpctd_pkg::OP_RD_FIFO);
  wire       is_wrf      = (burst_kind_reg == mpctd_pkg::OP_WR_FIFO);
  wire       reading     = is_cal | is_rdf;
  wire       preamble    = (burst_state_reg == mpctd_pkg::B_LAT) & ck_rise & (lat_cnt_reg == 6'h02) &
                           reading & ~train_active_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      burst_state_reg <= mpctd_pkg::B_IDLE;
      burst_kind_reg  <= mpctd_pkg::OP_NOP;
      lat_cnt_reg     <= 6'h00;
      beat_idx_reg    <= 5'h00;
    end else if (ce) begin
      unique case (burst_state_reg)
        mpctd_pkg::B_IDLE: begin
          // a command landing mid-burst is dropped; seamless bursts not supported
          if (launch) begin
            burst_kind_reg  <= pend_kind_reg;
            lat_cnt_reg     <= (pend_kind_reg == mpctd_pkg::OP_WR_FIFO) ? write_latency_reg
                                                                        : read_latency_reg;
            beat_idx_reg    <= 5'h00;
            burst_state_reg <= mpctd_pkg::B_LAT;
          end
        end
        mpctd_pkg::B_LAT: begin
          if (lat_done) begin
            beat_idx_reg    <= 5'h01;
            burst_state_reg <= mpctd_pkg::B_DATA;
          end else if (ck_rise) begin
            lat_cnt_reg <= lat_cnt_reg - 6'h01;
          end
        end
        mpctd_pkg::B_DATA: begin
          if (burst_end) begin
            burst_state_reg <= mpctd_pkg::B_IDLE;
          end else if (data_edge) begin
            beat_idx_reg <= beat_idx_reg + 5'h01;
          end
        end
        default: burst_state_reg <= mpctd_pkg::B_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
    end else if (ce && burst_end) begin
      if (is_wrf) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (is_rdf) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
    end
  end

  // training fifo storage
  mpctd_mem_if #(.W(18), .AW(7)) mem_bus ();
  assign mem_bus.wr_en   = beat_strobe & is_wrf;
  assign mem_bus.wr_addr = {wr_ptr_reg, cur_beat};
  assign mem_bus.wr_data = {dmi_h, dq_h};
  assign mem_bus.rd_addr = {rd_ptr_reg, cur_beat};

  mpctd_fifo_mem #(.WIDTH(18), .DEPTH(FIFO_ENTRIES * BEATS)) u_fifo (
    .clk  (clk),
    .ce   (ce),
    .port (mem_bus.mem)
  );

  // beat data
  wire        cal_bit  = cur_beat[3] ? pattern_high_register[cur_beat[2:0]]
                                     : pattern_low_register[cur_beat[2:0]];
  wire [15:0] cal_dq   = {16{cal_bit}} ^ invert_mask_reg;
  wire [15:0] beat_dq  = is_cal ? cal_dq : mem_bus.rd_data[15:0];
  wire [1:0]  beat_dmi = is_cal ? {2{cal_bit}} : mem_bus.rd_data[17:16];
  wire        dmi_any  = |dmi_en_reg;
  wire        idle     = (burst_state_reg == mpctd_pkg::B_IDLE);

  logic [15:0] dq_out_reg;
  logic        dq_oe_reg;
  logic [1:0]  dmi_out_reg;
  logic        dmi_oe_reg;
  logic        dqs_t_reg;
  logic        dqs_c_reg;
  logic        dqs_oe_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dq_out_reg  <= 16'h0000;
      dq_oe_reg   <= 1'b0;
      dmi_out_reg <= 2'h0;
      dmi_oe_reg  <= 1'b0;
      dqs_t_reg   <= 1'b0;
      dqs_c_reg   <= 1'b1;
      dqs_oe_reg  <= 1'b0;
    end else if (ce) begin
      if (beat_strobe && reading) begin
        dq_out_reg  <= beat_dq;
        dq_oe_reg   <= 1'b1;
        dmi_out_reg <= beat_dmi;
        dmi_oe_reg  <= is_cal | (is_rdf & dmi_any);
        dqs_t_reg   <= ~cur_beat[0];
        dqs_c_reg   <= cur_beat[0];
        dqs_oe_reg  <= 1'b1;
      end else if (preamble) begin
        dqs_t_reg  <= 1'b0;
        dqs_c_reg  <= 1'b1;
        dqs_oe_reg <= 1'b1;
      end else if (idle || burst_end) begin
        dq_oe_reg  <= 1'b0;
        dmi_oe_reg <= 1'b0;
        dqs_t_reg  <= 1'b0;
        dqs_c_reg  <= 1'b1;
        dqs_oe_reg <= train_active_reg;
      end
    end
  end

  assign prdata                 = prdata_reg;
  assign pready                 = pready_reg;
  assign pslverr                = pslverr_reg;
  assign dq_out                 = dq_out_reg;
  assign dq_oe                  = dq_oe_reg;
  assign mask_inversion_pin_out = dmi_out_reg;
  assign mask_inversion_pin_oe  = dmi_oe_reg;
  assign dqs_t                  = dqs_t_reg;
  assign dqs_c                  = dqs_c_reg;
  assign dqs_oe                 = dqs_oe_reg;
  assign impedance_cal_capture  = zq_capture_reg;

endmodule : mpctd_top

// File: tb/mpctd_props.sv
module mpctd_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        dq_oe,
  input wire logic        mask_inversion_pin_oe,
  input wire logic        dqs_t,
  input wire logic        dqs_c,
  input wire logic        dqs_oe,
  input wire logic        impedance_cal_capture
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] oe_cnt;
  always_ff @(posedge clk) oe_cnt <= dq_oe ? oe_cnt + 8'h01 : 8'h00;
  a_apb_answer: assert property (psel && penable && !pready |=> pready) else $error("late pready");
  a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  // skip the burst tail, where strobes may still settle
  a_train_level: assert property (!dq_oe [*4] ##0 dqs_oe |-> !dqs_t && dqs_c)
    else $error("bad strobe idle level");
  a_strobe_pair: assert property (dq_oe |-> dqs_oe && (dqs_c == !dqs_t))
    else $error("strobes not paired");
  a_mask_data: assert property (mask_inversion_pin_oe |-> dq_oe) else $error("mask pins alone");
  a_cap_pulse: assert property (impedance_cal_capture |=> !impedance_cal_capture)
    else $error("long latch pulse");
  // sixteen beats of 62.5 ns at 8 ns a cycle
  a_burst_len: assert property ($fell(dq_oe) |-> oe_cnt inside {[122:128]})
    else $error("bad burst length");
endmodule : mpctd_props
bind mpctd_top mpctd_props chk_u (.clk, .rst_n, .psel, .penable, .prdata, .pready, .dq_oe,
  .mask_inversion_pin_oe, .dqs_t, .dqs_c, .dqs_oe, .impedance_cal_capture);

// File: tb/mpctd_ctrl_model.sv
module mpctd_ctrl_model (
  input  wire logic        clk,
  output logic             ck_t,
  output logic             cs,
  output logic      [5:0]  ca,
  output logic      [15:0] dq_in,
  output logic      [1:0]  dmi_in,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  input  wire logic [1:0]  mask_inversion_pin_out,
  input  wire logic        impedance_cal_capture
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] beats[$];
  int          caps = 0;
  initial {ck_t, cs, ca, dmi_in, dq_in} = 26'h000A5A5;
  // clock stands low between frames; unused lines keep changing
  task automatic tick(input logic c, input logic [5:0] a);
    cs = c;
    ca = a;
    {dmi_in, dq_in} = ~{dmi_in, dq_in};
    #62.5 ck_t = 1'b1;
    #62.5 ck_t = 1'b0;
  endtask : tick
  task automatic mpc(input logic [6:0] op, input logic cas, input int n);
    tick(1'b1, {op[6], 5'h00});
    tick(1'b0, op[5:0]);
    if (cas) begin
      tick(1'b1, 6'h12);
      tick(1'b0, 6'h00);
    end
    repeat (n) tick(1'b0, ~ca);
  endtask : mpc
  // sample late in each beat, clear of the next launch
  always @(ck_t) #60 if (dq_oe === 1'b1) beats.push_back({mask_inversion_pin_out, dq_out});
  always @(posedge clk) if (impedance_cal_capture === 1'b1) caps++;
endmodule : mpctd_ctrl_model

// File: tb/mpctd_top_test.sv
module mpctd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [32:0] rd;
  logic        pready, pslverr, ck_t, cs, dq_oe, mpo_oe, dqs_t, dqs_c, dqs_oe, cap;
  logic [5:0]  ca;
  logic [15:0] dq_in, dq_out;
  logic [1:0]  dmi_in, mpo;
  int          err_count = 0, compares = 0;
  always #4 clk = ~clk;
  mpctd_top dut_u (.clk, .rst_n, .ce(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .ck_t, .cs, .ca, .dq_in, .dmi_in, .dq_out, .dq_oe, .mask_inversion_pin_out(mpo),
    .mask_inversion_pin_oe(mpo_oe), .dqs_t, .dqs_c, .dqs_oe, .impedance_cal_capture(cap));
  mpctd_ctrl_model ctl_u (.clk, .ck_t, .cs, .ca, .dq_in, .dmi_in, .dq_out, .dq_oe,
    .mask_inversion_pin_out(mpo), .impedance_cal_capture(cap));
  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = {pslverr, prdata};
    cmp("pready", 1, pready);
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic t_cal;
    logic [15:0] pat = 16'hC33C;
    logic        b;
    apb(0, 8'h04, 0);
    cmp("pattern low", 33'h55, rd);
    apb(0, 8'hFC, 0);
    cmp("unmapped", 33'h100000000, rd);
    apb(1, 8'h04, 32'h3C);
    apb(1, 8'h08, 32'hC3);
    apb(1, 8'h0C, 32'h0F0F);
    apb(1, 8'h14, 32'h2);
    apb(1, 8'h00, 32'h2);
    repeat (10) @(posedge clk);
    cmp("train strobes", 3'b101, {dqs_oe, dqs_t, dqs_c});
    ctl_u.beats.delete();
    ctl_u.mpc(7'h43, 1, 18);
    cmp("beat count", 16, ctl_u.beats.size());
    foreach (ctl_u.beats[i]) begin
      b = pat[i];
      cmp("cal beat", {15'h0, {2{b}}, {16{b}} ^ 16'h0F0F}, ctl_u.beats[i]);
    end
    apb(1, 8'h00, 32'h0);
    repeat (10) @(posedge clk);
    cmp("train exit", 0, dqs_oe);
  endtask : t_cal
  task automatic t_misc;
    ctl_u.beats.delete();
    ctl_u.mpc(7'h3F, 0, 18);
    ctl_u.mpc(7'h45, 1, 18);
    cmp("nop beats", 0, ctl_u.beats.size());
    ctl_u.mpc(7'h51, 0, 4);
    cmp("latch pulses", 1, ctl_u.caps);
    apb(1, 8'h00, 32'h1);
    ctl_u.mpc(7'h4D, 0, 2);
    apb(0, 8'h24, 0);
    cmp("osc running", 0, rd[2]);
    apb(0, 8'h18, 0);
    cmp("count stored", 1, rd != 0);
    ctl_u.mpc(7'h4F, 0, 0);
    apb(0, 8'h24, 0);
    cmp("zq busy", 1, rd[1]);
    // a restart would keep busy past this read
    ctl_u.mpc(7'h4F, 0, 0);
    repeat (100) @(posedge clk);
    apb(0, 8'h24, 0);
    cmp("zq done", 0, rd[1]);
  endtask : t_misc
  // data pins flip once per link cycle, so beats pair up and pairs alternate
  task automatic t_fifo;
    logic [17:0] v;
    ctl_u.mpc(7'h47, 1, 18);
    v = {dmi_in, dq_in};
    ctl_u.beats.delete();
    ctl_u.mpc(7'h41, 1, 18);
    cmp("fifo beat count", 16, ctl_u.beats.size());
    foreach (ctl_u.beats[i]) begin
      cmp("fifo beat", {15'h0, i[1] ? ~v : v}, ctl_u.beats[i]);
    end
  endtask : t_fifo
  task automatic conclude;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_cal;
    t_misc;
    t_fifo;
    conclude;
  end
  initial begin
    #200000;
    err_count++;
    conclude;
  end
endmodule : mpctd_top_test
